/* core/pots_regs.sv */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE1: Software keeps the upper sixteen bits of the drive-type register at zero.
// RULE2: The drive-type register holds one software read-write bit per pin, bit n for pin n.
// RULE3: A drive-type bit of 0 means push-pull and is the reset state; 1 means open-drain.
// RULE4: The speed register sits at offset 0x08 and is read-write.
// RULE5: The speed register holds a two-bit field per pin at bits 2n+1 down to 2n.
// RULE6: The speed register resets to 0x0c000000 on port A and to zero elsewhere.
// RULE7: Speed code x0 gives 2 MHz, 01 gives 10 MHz and 11 gives 50 MHz.
// RULE8: The drive-type register sits at offset 0x04 and resets to zero.
// RULE9: Drive type and speed apply only when a pin is in output or alternate mode.
// RULE10: Open-drain pulls low for a 0 and floats for a 1; push-pull drives both levels.
module pots_regs
   import pots_pkg::*;
#(
   parameter bit IS_PORT_A = 1'b0
)
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [POTS_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output var  logic                   awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output var  logic                   wready,
   output var  logic [1:0]             bresp,
   output var  logic                   bvalid,
   input  wire logic                   bready,
   input  wire logic [POTS_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output var  logic                   arready,
   output var  logic [31:0]            rdata,
   output var  logic [1:0]             rresp,
   output var  logic                   rvalid,
   input  wire logic                   rready,
   input  wire logic [15:0]            alt_level,
   output var  pots_pad_t              pad,
   output var  logic [31:0]            pad_slew
);

   logic [31:0]            pin_config_field;
   logic [31:0]            pin_drive_type;
   logic [31:0]            pin_speed_select;
   logic [31:0]            out_value;
   logic                   aw_held;
   logic                   w_held;
   logic [POTS_ADDR_W-1:0] wr_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   logic                   commit;
   pots_pad_t              next_pad;
   logic [31:0]            next_slew;

   // Merge write data into a register under byte enables, then clear fixed bits.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (wr_strb[b])
         begin
            res[8*b +: 8] = wr_data[8*b +: 8];
         end
      end
      return res & mask;
   endfunction

   // A write commits once both address and data are held and no response is pending.
   assign commit = aw_held && w_held && !bvalid;

   // Write address channel; ready returns only after the response has gone.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         wr_addr <= '0;
      end
      else if (awvalid && awready)
      begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         wr_addr <= awaddr;
      end
      else if (commit)
      begin
         aw_held <= 1'b0;
      end
      else if (!aw_held && !bvalid)
      begin
         awready <= 1'b1;
      end
   end

   // Write data channel, independent of the address so either may come first.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready  <= 1'b0;
         w_held  <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end
      else if (wvalid && wready)
      begin
         wready  <= 1'b0;
         w_held  <= 1'b1;
         wr_data <= wdata;
         wr_strb <= wstrb;
      end
      else if (commit)
      begin
         w_held <= 1'b0;
      end
      else if (!w_held && !bvalid)
      begin
         wready <= 1'b1;
      end
   end

   // Write response; unmapped or read-only offsets answer with a slave error.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= POTS_RESP_OKAY;
      end
      else if (commit)
      begin
         bvalid <= 1'b1;
         case (wr_addr)
            POTS_OFF_CONFIG, POTS_OFF_DRIVE, POTS_OFF_SPEED, POTS_OFF_OUTVAL:
               bresp <= POTS_RESP_OKAY;
            default:
               bresp <= POTS_RESP_SLVERR;
         endcase
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // Configuration fields; port A starts with its debug pins in alternate mode.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_config_field <= IS_PORT_A ? POTS_RST_CONFIG_A : POTS_RST_ZERO;
      end
      else if (commit && wr_addr == POTS_OFF_CONFIG)
      begin
         pin_config_field <= merge(pin_config_field, '1);
      end
   end

   // Drive-type bits are changed only by software; the upper half never stores anything.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_drive_type <= POTS_RST_ZERO; // RULE8 RULE3
      end
      else if (commit && wr_addr == POTS_OFF_DRIVE) // RULE8
      begin
         pin_drive_type <= merge(pin_drive_type, POTS_MASK_LOW16); // RULE2 RULE1
      end
   end

   // Speed fields, one pair per pin, fully writable.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_speed_select <= IS_PORT_A ? POTS_RST_SPEED_A : POTS_RST_ZERO; // RULE6
      end
      else if (commit && wr_addr == POTS_OFF_SPEED) // RULE4
      begin
         pin_speed_select <= merge(pin_speed_select, '1); // RULE5
      end
   end

   // Output values for pins in general output mode.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_value <= POTS_RST_ZERO;
      end
      else if (commit && wr_addr == POTS_OFF_OUTVAL)
      begin
         out_value <= merge(out_value, POTS_MASK_LOW16);
      end
   end

   // Read channel; data is sampled at the address handshake, so a read that
   // overlaps a write sees the value before that write.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= POTS_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= POTS_RESP_OKAY;
         case (araddr)
            POTS_OFF_CONFIG: rdata <= pin_config_field;
            POTS_OFF_DRIVE:  rdata <= pin_drive_type; // RULE2
            POTS_OFF_SPEED:  rdata <= pin_speed_select; // RULE4
            POTS_OFF_OUTVAL: rdata <= out_value;
            POTS_OFF_STATE:  rdata <= {pad.enable, pad.level};
            default:
            begin
               rdata <= '0;
               rresp <= POTS_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
      end
      else if (!rvalid)
      begin
         arready <= 1'b1;
      end
   end

   // Per-pin pad decode: source selection, drive style and slew.
   for (genvar n = 0; n < POTS_PINS; n++)
   begin : g_pin
      logic [1:0] mode;
      logic [1:0] spd;
      logic       driving;
      logic       value;
      assign mode    = pin_config_field[2*n +: 2];
      assign spd     = pin_speed_select[2*n +: 2]; // RULE5
      assign driving = (mode == POTS_CFG_OUTPUT) || (mode == POTS_CFG_ALT); // RULE9
      assign value   = (mode == POTS_CFG_ALT) ? alt_level[n] : out_value[n];

      // Open-drain only ever drives a low; a high is left to the external pull.
      // Each pin bit has its own continuous driver, so no two processes share next_pad.
      assign next_pad.level[n]  = driving && !pin_drive_type[n] && value; // RULE10
      assign next_pad.enable[n] = driving && (pin_drive_type[n] ? !value : 1'b1); // RULE3
      // Code 10 folds onto the slow rate, so the pad never sees a code it cannot honour.
      assign next_slew[2*n +: 2] = !driving ? POTS_SLEW_SLOW : // RULE9
                                   !spd[0]  ? POTS_SLEW_SLOW : // RULE7
                                   !spd[1]  ? POTS_SLEW_MID  : POTS_SLEW_FAST;
   end

   // Pad outputs are registered so they change one cycle after their cause.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pad      <= '0;
         pad_slew <= '0;
      end
      else
      begin
         pad      <= next_pad;
         pad_slew <= next_slew;
      end
   end

endmodule

`default_nettype wire

/* core/pots_pkg.sv */
package pots_pkg;

   // Bus geometry.
   localparam int unsigned POTS_DATA_W = 32;
   localparam int unsigned POTS_ADDR_W = 8;
   localparam int unsigned POTS_PINS   = 16;

   // Register byte offsets.
   localparam logic [7:0] POTS_OFF_CONFIG = 8'h00;
   localparam logic [7:0] POTS_OFF_DRIVE  = 8'h04;
   localparam logic [7:0] POTS_OFF_SPEED  = 8'h08;
   localparam logic [7:0] POTS_OFF_OUTVAL = 8'h14;
   localparam logic [7:0] POTS_OFF_STATE  = 8'h18;

   // Reset values; the port A flavour differs for config and speed.
   localparam logic [31:0] POTS_RST_CONFIG_A = 32'h2800_0000;
   localparam logic [31:0] POTS_RST_SPEED_A  = 32'h0c00_0000;
   localparam logic [31:0] POTS_RST_ZERO     = 32'h0000_0000;

   // Writable bits of the drive-type and output value registers.
   localparam logic [31:0] POTS_MASK_LOW16 = 32'h0000_ffff;

   // Pin configuration field codes.
   localparam logic [1:0] POTS_CFG_INPUT  = 2'h0;
   localparam logic [1:0] POTS_CFG_OUTPUT = 2'h1;
   localparam logic [1:0] POTS_CFG_ALT    = 2'h2;
   localparam logic [1:0] POTS_CFG_ANALOG = 2'h3;

   // Normalised slew codes driven to the pad: slow 2 MHz, mid 10 MHz, fast 50 MHz.
   localparam logic [1:0] POTS_SLEW_SLOW = 2'h0;
   localparam logic [1:0] POTS_SLEW_MID  = 2'h1;
   localparam logic [1:0] POTS_SLEW_FAST = 2'h3;

   // AXI responses.
   localparam logic [1:0] POTS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] POTS_RESP_SLVERR = 2'h2;

   // Pad drive bundle: output level and output enable per pin.
   typedef struct packed {
      logic [15:0] level;
      logic [15:0] enable;
   } pots_pad_t;

endpackage

/* bench/pots_regs_props.sv */
`timescale 1ns/1ns
`default_nettype none

// Watches the bus handshakes and the pad outputs of the register block.
module pots_regs_props
   import pots_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire pots_pad_t   pad,
   input wire logic [31:0] pad_slew
);
   logic slew_ok;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // A 10 code must never reach a pad, since the pad has no such rate.
   always_comb
   begin
      slew_ok = 1'b1;
      for (int i = 0; i < 16; i++)
         if (pad_slew[2*i+:2] == 2'h2)
            slew_ok = 1'b0;
   end

   AST_AW_TAKE: assert property (awvalid && awready |=> !awready)
      else $error("awready stayed high after a taken address");
   AST_W_TAKE: assert property (wvalid && wready |=> !wready)
      else $error("wready stayed high after taken data");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped or changed before bready");
   AST_B_DONE: assert property (bvalid && bready |=> !bvalid ##1 awready && wready)
      else $error("write channel did not recover after response");
   AST_R_ANS: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer not one cycle after address");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped or changed before rready");
   AST_R_DONE: assert property (rvalid && rready |=> !rvalid ##1 arready)
      else $error("read channel did not recover after data");
   AST_SLEW: assert property (slew_ok)
      else $error("pad slew carries code 10");
   AST_OD: assert property ((pad.level & ~pad.enable) == 16'h0)
      else $error("high level on an undriven pin");

   cover property (bvalid && bready && bresp == POTS_RESP_SLVERR);
   cover property (rvalid && rready);
   cover property (pad.enable != 16'h0 && pad.level == 16'h0);
endmodule

`default_nettype wire

/* bench/pots_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module pots_regs_tb
   import pots_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, pad_slew, m_cfg, m_drv, m_spd, m_out;
   logic [31:0] other_rdata, other_seen;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] alt_level;
   pots_pad_t   pad;
   integer      seed, miscompares, checked, cyc;

   pots_regs #(.IS_PORT_A(1'b1)) pots_regs_inst
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .awaddr    (awaddr),
      .awvalid   (awvalid),
      .awready   (awready),
      .wdata     (wdata),
      .wstrb     (wstrb),
      .wvalid    (wvalid),
      .wready    (wready),
      .bresp     (bresp),
      .bvalid    (bvalid),
      .bready    (bready),
      .araddr    (araddr),
      .arvalid   (arvalid),
      .arready   (arready),
      .rdata     (rdata),
      .rresp     (rresp),
      .rvalid    (rvalid),
      .rready    (rready),
      .alt_level (alt_level),
      .pad       (pad),
      .pad_slew  (pad_slew)
   );

   // A port with the plain reset values on the same bus; its handshakes match the
   // first instance, so only its read data is watched.
   pots_regs #(.IS_PORT_A(1'b0)) pots_regs_other_inst
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .awaddr    (awaddr),
      .awvalid   (awvalid),
      .awready   (),
      .wdata     (wdata),
      .wstrb     (wstrb),
      .wvalid    (wvalid),
      .wready    (),
      .bresp     (),
      .bvalid    (),
      .bready    (bready),
      .araddr    (araddr),
      .arvalid   (arvalid),
      .arready   (),
      .rdata     (other_rdata),
      .rresp     (),
      .rvalid    (),
      .rready    (rready),
      .alt_level (alt_level),
      .pad       (),
      .pad_slew  ()
   );

   always #2 aclk = ~aclk;

   // Cuts a hang short; the whole run needs about 650 cycles.
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         miscompares++;
         wrap_up;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Address and data go out together; each is dropped on its own ready.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         pa = pa && !awready;
         pw = pw && !wready;
         awvalid <= pa;
         wvalid <= pw;
      end
      while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic pa;
      pa = 1'b1;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         pa = pa && !arready;
         arvalid <= pa;
      end
      while (!rvalid);
      rready <= 1'b0;
      other_seen = other_rdata;
      chk(rdata, e, "rdata");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
      @(posedge aclk);
   endtask

   // Expected pads come from the model registers, pin by pin.
   task automatic cmp_pins;
      logic [1:0]  md, sp;
      logic        v;
      pots_pad_t   ep;
      logic [31:0] es;
      ep = '0;
      es = 32'h0;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 16; i++)
      begin
         md = m_cfg[2*i+:2];
         sp = m_spd[2*i+:2];
         v = (md == POTS_CFG_OUTPUT) ? m_out[i] : alt_level[i];
         if (md == POTS_CFG_OUTPUT || md == POTS_CFG_ALT)
         begin
            ep.enable[i] = m_drv[i] ? !v : 1'b1;
            ep.level[i] = m_drv[i] ? 1'b0 : v;
            es[2*i+:2] = sp[0] ? sp : POTS_SLEW_SLOW;
         end
      end
      chk(pad, ep, "pad");
      chk(pad_slew, es, "pad_slew");
   endtask

   // Reset values, random traffic on the four writable registers, then refused accesses.
   initial
   begin
      seed = 32'h4d7a;
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata, alt_level} = 64'h0;
      wstrb = 4'hf;
      miscompares = 0;
      checked = 0;
      cyc = 0;
      m_cfg = POTS_RST_CONFIG_A;
      m_spd = POTS_RST_SPEED_A;
      m_drv = POTS_RST_ZERO;
      m_out = POTS_RST_ZERO;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      cmp_pins;
      axi_rd(POTS_OFF_DRIVE, POTS_RST_ZERO, POTS_RESP_OKAY);
      axi_rd(POTS_OFF_SPEED, POTS_RST_SPEED_A, POTS_RESP_OKAY);
      chk(other_seen, POTS_RST_ZERO, "speed_other");
      for (int k = 0; k < 24; k++)
      begin
         m_cfg = $random(seed);
         m_drv = $random(seed) & POTS_MASK_LOW16;
         m_spd = $random(seed);
         m_out = $random(seed);
         alt_level <= 16'($random(seed));
         axi_wr(POTS_OFF_CONFIG, m_cfg, POTS_RESP_OKAY);
         axi_wr(POTS_OFF_DRIVE, m_drv, POTS_RESP_OKAY);
         axi_wr(POTS_OFF_SPEED, m_spd, POTS_RESP_OKAY);
         axi_wr(POTS_OFF_OUTVAL, m_out, POTS_RESP_OKAY);
         m_drv = m_drv & POTS_MASK_LOW16;
         m_out = m_out & POTS_MASK_LOW16;
         axi_rd(POTS_OFF_DRIVE, m_drv, POTS_RESP_OKAY);
         axi_rd(POTS_OFF_SPEED, m_spd, POTS_RESP_OKAY);
         cmp_pins;
      end
      // One byte lane only: the other speed fields must keep their values.
      wstrb <= 4'h4;
      axi_wr(POTS_OFF_SPEED, ~m_spd, POTS_RESP_OKAY);
      wstrb <= 4'hf;
      m_spd[23:16] = ~m_spd[23:16];
      axi_rd(POTS_OFF_SPEED, m_spd, POTS_RESP_OKAY);
      axi_wr(8'h3c, 32'hffff_ffff, POTS_RESP_SLVERR);
      axi_wr(POTS_OFF_STATE, 32'hffff_ffff, POTS_RESP_SLVERR);
      axi_rd(8'h3c, POTS_RST_ZERO, POTS_RESP_SLVERR);
      axi_rd(POTS_OFF_SPEED, m_spd, POTS_RESP_OKAY);
      cmp_pins;
      wrap_up;
   end
endmodule

bind pots_regs pots_regs_props pots_regs_props_inst
(
   .aclk     (aclk),
   .aresetn  (aresetn),
   .awvalid  (awvalid),
   .awready  (awready),
   .wvalid   (wvalid),
   .wready   (wready),
   .bresp    (bresp),
   .bvalid   (bvalid),
   .bready   (bready),
   .arvalid  (arvalid),
   .arready  (arready),
   .rdata    (rdata),
   .rvalid   (rvalid),
   .rready   (rready),
   .pad      (pad),
   .pad_slew (pad_slew)
);

`default_nettype wire
